/* logic/ccg_pkg.sv */
// package of offsets, fields, reset values and carrier types for the clock gating block
package ccg_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_SYS_EN      = 8'h00;
  localparam logic [7:0] OFF_SYS_DIS     = 8'h04;
  localparam logic [7:0] OFF_SYS_STAT    = 8'h08;
  localparam logic [7:0] OFF_PER_EN      = 8'h10;
  localparam logic [7:0] OFF_PER_DIS     = 8'h14;
  localparam logic [7:0] OFF_PER_STAT    = 8'h18;
  localparam logic [7:0] OFF_OSC_CFG     = 8'h20;
  localparam logic [7:0] OFF_FREQ        = 8'h24;
  localparam logic [7:0] OFF_PLL_CFG     = 8'h2c;
  localparam logic [7:0] OFF_SHARED_STAT = 8'h68;

  // field positions
  localparam int SYS_CPU_BIT    = 0;
  localparam int SYS_USB_BIT    = 7;
  localparam int SYS_PROG_LSB   = 8;
  localparam int OSC_EN_BIT     = 0;
  localparam int OSC_BYP_BIT    = 1;
  localparam int OSC_DLY_LSB    = 8;
  localparam int FREQ_VALID_BIT = 16;
  localparam int PLL_DIV_LSB    = 0;
  localparam int PLL_CNT_LSB    = 8;
  localparam int PLL_RANGE_LSB  = 14;
  localparam int PLL_MUL_LSB    = 16;
  localparam int PLL_USB_LSB    = 28;
  localparam int SR_MAIN_OSC_STABLE_FLAG_BIT   = 0;
  localparam int SR_LOCK_BIT    = 2;
  localparam int SR_MCKRDY_BIT  = 3;

  // reset values
  localparam logic [31:0] SYS_STAT_RST = 32'h0000_0001;
  localparam logic [31:0] PLL_CFG_RST  = 32'h0000_3f00;

  // timing counts, in slow clock cycles
  localparam logic [10:0] OSC_DLY_SCALE = 11'h008;
  localparam logic [4:0]  FREQ_WINDOW   = 5'h10;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ccg_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ccg_apb_rsp_t;

  typedef enum logic [1:0] {MEAS_WAIT, MEAS_RUN, MEAS_DONE} ccg_meas_t;

endpackage

/* logic/ccg_clock_ctrl.sv */
// clock gating, oscillator, frequency meter and pll settings with an apb register slave
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps

// What this block does
// - status bit 0 reads one while the processor clock runs, zero when stopped.
// - status bit 7 shows whether the 48 MHz usb port clock is enabled.
// - status bits 8 to 11 show each programmable clock output's enable.
// - writing one to enable bit x (2..31) switches peripheral clock x on.
// - bits of unimplemented peripherals are ignored and always read zero.
// - writing one to disable bit x switches peripheral clock x off.
// - peripheral status bit x reads one while clock x is enabled.
// - with the oscillator enabled, stable flag rises after the start-up interval.
// - with bypass set, the stable flag is set at once.
// - clearing enable and bypass clears the stable flag.
// - start-up field in bits 8..15 gives a delay of value times 8 slow cycles.
// - low 16 bits of frequency register count main cycles in 16 slow periods.
// - frequency valid bit 16 is one only after oscillator on or bypassed and measure done.
// - pll input divider 0 gives no output, 1 bypasses, 2..255 divide.
// - after each pll write, lock waits the settle count of slow cycles.
// - multiplier zero turns pll off, otherwise output is input times value+1.
// - usb divider 00 undivided, 01 by 2, 10 by 4, 11 reserved.
// - shared status lock flag reads zero unlocked, one once locked.
// - writing one to system disable bit 0 stops the processor clock.
module ccg_clock_ctrl #(
  parameter logic [31:0] PERIPH_MASK = 32'hffff_fffc
) (
  input  wire logic                  clk,               // 100 MHz system clock
  input  wire logic                  rstn,              // async reset
  input  wire ccg_pkg::ccg_apb_req_t apbReq,            // apb request group
  output ccg_pkg::ccg_apb_rsp_t      apbRsp,            // apb answer group
  input  wire logic                  slowClkIn,         // slow clock pin, sampled
  input  wire logic                  mainClkIn,         // main clock, sampled
  output logic                       cpuClockState,     // processor clock enable
  output logic                       usbPortClockState, // usb 48 MHz clock enable
  output logic [3:0]                 progClockState,    // programmable clock enables
  output logic [31:0]                peripheralGate,    // peripheral clock enables
  output logic                       mainOscEnable,     // oscillator run
  output logic                       oscBypassSelect,   // external clock on crystal in
  output logic                       mainOscStableFlag, // oscillator stable
  output logic                       pllLockFlag,       // pll locked
  output logic                       pllRun,            // pll active
  output logic [7:0]                 pllDivide,         // pll input divider
  output logic [10:0]                pllFeedbackFactor, // pll multiplier field
  output logic [1:0]                 pllRange,          // pll frequency range
  output logic [1:0]                 usbClockShift      // usb divide as power of two
);
  import ccg_pkg::*;

  typedef struct packed {
    logic        cpuOn;
    logic        usbOn;
    logic [3:0]  prog;
    logic [31:0] periph;
    logic        oscEn;
    logic        oscByp;
    logic [7:0]  oscDly;
    logic [10:0] oscCnt;
    logic        main_osc_stable_flag;
    ccg_meas_t   meas;
    logic [4:0]  slowCnt;
    logic [15:0] mainCnt;
    logic [15:0] freq;
    logic        freqValid;
    logic [7:0]  pllDiv;
    logic [5:0]  pllCnt;
    logic [1:0]  pllRng;
    logic [10:0] pllMul;
    logic [1:0]  usbRatio;
    logic [5:0]  lockCnt;
    logic        lock;
    logic        pllOn;
    logic [1:0]  usbShift;
    logic [31:0] rdata;
    logic        err;
    logic [2:0]  slowSync;
    logic [2:0]  mainSync;
  } ccg_state_t;

  localparam ccg_state_t ST_RST = '{
    cpuOn:   SYS_STAT_RST[SYS_CPU_BIT],
    usbOn:   SYS_STAT_RST[SYS_USB_BIT],
    prog:    SYS_STAT_RST[SYS_PROG_LSB +: 4],
    pllDiv:  PLL_CFG_RST[PLL_DIV_LSB +: 8],
    pllCnt:  PLL_CFG_RST[PLL_CNT_LSB +: 6],
    pllRng:  PLL_CFG_RST[PLL_RANGE_LSB +: 2],
    pllMul:  PLL_CFG_RST[PLL_MUL_LSB +: 11],
    usbRatio: PLL_CFG_RST[PLL_USB_LSB +: 2],
    lockCnt: PLL_CFG_RST[PLL_CNT_LSB +: 6],
    meas:    MEAS_WAIT,
    default: '0
  };

  ccg_state_t st_q;
  ccg_state_t st_d;

  logic        setupRd;
  logic        accWr;
  logic        slowTick;
  logic        mainEdge;
  logic [31:0] wd;
  logic [31:0] rmux;
  logic        rerr;

  assign wd      = apbReq.pwdata;
  assign setupRd = apbReq.psel && !apbReq.penable;
  assign accWr   = apbReq.psel && apbReq.penable && apbReq.pwrite;
  // only the second and third stages are compared, never the first
  assign slowTick = st_q.slowSync[1] && !st_q.slowSync[2];
  assign mainEdge = st_q.mainSync[1] && !st_q.mainSync[2];

  // read data is captured in the setup cycle so prdata comes from a flop
  always_comb begin
    rmux = '0;
    rerr = 1'b0;
    if (apbReq.paddr == OFF_SYS_STAT) begin
      rmux[SYS_CPU_BIT] = st_q.cpuOn;
      rmux[SYS_USB_BIT] = st_q.usbOn;
      rmux[SYS_PROG_LSB +: 4] = st_q.prog;
    end else if (apbReq.paddr == OFF_PER_STAT) begin
      rmux = st_q.periph;
    end else if (apbReq.paddr == OFF_OSC_CFG) begin
      rmux[OSC_EN_BIT] = st_q.oscEn;
      rmux[OSC_BYP_BIT] = st_q.oscByp;
      rmux[OSC_DLY_LSB +: 8] = st_q.oscDly;
    end else if (apbReq.paddr == OFF_FREQ) begin
      rmux[15:0] = st_q.freq;
      rmux[FREQ_VALID_BIT] = st_q.freqValid;
    end else if (apbReq.paddr == OFF_PLL_CFG) begin
      rmux[PLL_DIV_LSB +: 8] = st_q.pllDiv;
      rmux[PLL_CNT_LSB +: 6] = st_q.pllCnt;
      rmux[PLL_RANGE_LSB +: 2] = st_q.pllRng;
      rmux[PLL_MUL_LSB +: 11] = st_q.pllMul;
      rmux[PLL_USB_LSB +: 2] = st_q.usbRatio;
    end else if (apbReq.paddr == OFF_SHARED_STAT) begin
      rmux[SR_MAIN_OSC_STABLE_FLAG_BIT] = st_q.main_osc_stable_flag;
      rmux[SR_LOCK_BIT] = st_q.lock;
      // master clock selection lives elsewhere; reported ready
      rmux[SR_MCKRDY_BIT] = 1'b1;
    end else if (apbReq.paddr == OFF_SYS_EN || apbReq.paddr == OFF_SYS_DIS ||
                 apbReq.paddr == OFF_PER_EN || apbReq.paddr == OFF_PER_DIS) begin
      rmux = '0;
    end else begin
      rerr = 1'b1;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.slowSync = {st_q.slowSync[1:0], slowClkIn};
    st_d.mainSync = {st_q.mainSync[1:0], mainClkIn};
    if (setupRd) begin
      st_d.rdata = rmux;
      st_d.err = rerr;
    end

    // oscillator start-up countdown
    if (st_q.oscEn && !st_q.main_osc_stable_flag) begin
      if (st_q.oscCnt == '0) begin
        st_d.main_osc_stable_flag = 1'b1;
      end else if (slowTick) begin
        st_d.oscCnt = st_q.oscCnt - 11'h001;
      end
    end

    // pll settle countdown; a pll with zero multiplier never locks
    if (!st_q.lock && st_q.pllMul != '0) begin
      if (st_q.lockCnt == '0) begin
        st_d.lock = 1'b1;
      end else if (slowTick) begin
        st_d.lockCnt = st_q.lockCnt - 6'h01;
      end
    end

    // frequency meter, aligned to a slow clock edge
    case (st_q.meas)
      MEAS_WAIT: begin
        if (st_q.main_osc_stable_flag && slowTick) begin
          st_d.meas = MEAS_RUN;
          st_d.slowCnt = '0;
          st_d.mainCnt = '0;
        end
      end
      MEAS_RUN: begin
        if (mainEdge && st_q.mainCnt != 16'hffff) begin
          st_d.mainCnt = st_q.mainCnt + 16'h0001;
        end
        if (slowTick) begin
          st_d.slowCnt = st_q.slowCnt + 5'h01;
          if (st_q.slowCnt + 5'h01 == FREQ_WINDOW) begin
            st_d.meas = MEAS_DONE;
            // saturated count must not wrap on the closing edge
            st_d.freq = st_q.mainCnt +
                        {15'h0000, mainEdge && st_q.mainCnt != 16'hffff};
            st_d.freqValid = 1'b1;
          end
        end
      end
      MEAS_DONE: begin
        st_d.meas = MEAS_DONE;
      end
      default: begin
        st_d.meas = MEAS_WAIT;
      end
    endcase
    if (!st_q.oscEn && !st_q.oscByp) begin
      st_d.meas = MEAS_WAIT;
      st_d.freqValid = 1'b0;
    end

    // register writes take effect on the access edge
    if (accWr) begin
      if (apbReq.paddr == OFF_SYS_EN) begin
        st_d.usbOn = st_q.usbOn | wd[SYS_USB_BIT];
        st_d.prog = st_q.prog | wd[SYS_PROG_LSB +: 4];
      end else if (apbReq.paddr == OFF_SYS_DIS) begin
        st_d.cpuOn = st_q.cpuOn & ~wd[SYS_CPU_BIT];
        st_d.usbOn = st_q.usbOn & ~wd[SYS_USB_BIT];
        st_d.prog = st_q.prog & ~wd[SYS_PROG_LSB +: 4];
      end else if (apbReq.paddr == OFF_PER_EN) begin
        st_d.periph = st_q.periph | (wd & PERIPH_MASK);
      end else if (apbReq.paddr == OFF_PER_DIS) begin
        st_d.periph = st_q.periph & ~(wd & PERIPH_MASK);
      end else if (apbReq.paddr == OFF_OSC_CFG) begin
        st_d.oscEn = wd[OSC_EN_BIT];
        st_d.oscByp = wd[OSC_BYP_BIT];
        st_d.oscDly = wd[OSC_DLY_LSB +: 8];
        // bypass wins if software breaks the exclusive setting
        if (wd[OSC_BYP_BIT]) begin
          st_d.main_osc_stable_flag = 1'b1;
        end else if (!wd[OSC_EN_BIT]) begin
          st_d.main_osc_stable_flag = 1'b0;
          // invalidate with the flag, not one cycle later
          st_d.freqValid = 1'b0;
          st_d.meas = MEAS_WAIT;
        end else if (!st_q.oscEn || st_q.oscByp) begin
          // fresh start-up: restart the interval
          st_d.main_osc_stable_flag = 1'b0;
          st_d.oscCnt = 11'(wd[OSC_DLY_LSB +: 8] * OSC_DLY_SCALE);
        end
      end else if (apbReq.paddr == OFF_PLL_CFG) begin
        st_d.pllDiv = wd[PLL_DIV_LSB +: 8];
        st_d.pllCnt = wd[PLL_CNT_LSB +: 6];
        st_d.pllRng = wd[PLL_RANGE_LSB +: 2];
        st_d.pllMul = wd[PLL_MUL_LSB +: 11];
        st_d.usbRatio = wd[PLL_USB_LSB +: 2];
        st_d.lock = 1'b0;
        st_d.lockCnt = wd[PLL_CNT_LSB +: 6];
      end
    end

    // pll runs only with a nonzero divider and multiplier
    st_d.pllOn = (st_d.pllMul != '0) && (st_d.pllDiv != '0);
    case (st_d.usbRatio)
      2'b00: st_d.usbShift = 2'd0;
      2'b01: st_d.usbShift = 2'd1;
      2'b10: st_d.usbShift = 2'd2;
      default: st_d.usbShift = st_q.usbShift;         // reserved keeps last
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // no wait state: setup captures, access answers
  assign apbRsp.pready  = apbReq.psel && apbReq.penable;
  assign apbRsp.prdata  = st_q.rdata;
  assign apbRsp.pslverr = apbReq.psel && apbReq.penable && st_q.err;

  assign cpuClockState     = st_q.cpuOn;
  assign usbPortClockState = st_q.usbOn;
  assign progClockState    = st_q.prog;
  assign peripheralGate    = st_q.periph;
  assign mainOscEnable     = st_q.oscEn;
  assign oscBypassSelect   = st_q.oscByp;
  assign mainOscStableFlag = st_q.main_osc_stable_flag;
  assign pllLockFlag       = st_q.lock;
  assign pllRun            = st_q.pllOn;
  assign pllDivide         = st_q.pllDiv;
  assign pllFeedbackFactor = st_q.pllMul;
  assign pllRange          = st_q.pllRng;
  assign usbClockShift     = st_q.usbShift;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_cpu_stop: assert property (
    accWr && apbReq.paddr == OFF_SYS_DIS && apbReq.pwdata[0] |=> !cpuClockState)
    else $error("cpu clock still on after disable");

  chk_per_enable: assert property (
    accWr && apbReq.paddr == OFF_PER_EN
      |=> ((peripheralGate & $past(apbReq.pwdata) & PERIPH_MASK)
           == ($past(apbReq.pwdata) & PERIPH_MASK)))
    else $error("peripheral enable write not applied");

  chk_per_disable: assert property (
    accWr && apbReq.paddr == OFF_PER_DIS
      |=> ((peripheralGate & $past(apbReq.pwdata)) == '0))
    else $error("peripheral disable write not applied");

  chk_unimpl_bits: assert property (
    (peripheralGate & ~PERIPH_MASK) == '0)
    else $error("unimplemented peripheral bit set");

  chk_status_read: assert property (
    apbRsp.pready && !apbReq.pwrite && apbReq.paddr == OFF_PER_STAT
      |-> apbRsp.prdata == peripheralGate)
    else $error("peripheral status read mismatch");

  chk_bypass_stable: assert property (
    accWr && apbReq.paddr == OFF_OSC_CFG && apbReq.pwdata[1]
      |=> mainOscStableFlag [*2])
    else $error("bypass did not set stable flag");

  chk_osc_off_clear: assert property (
    accWr && apbReq.paddr == OFF_OSC_CFG && apbReq.pwdata[1:0] == 2'b00
      |=> !mainOscStableFlag && !st_q.freqValid)
    else $error("stable flag not cleared by oscillator off");

  chk_osc_wait: assert property (
    $rose(mainOscStableFlag) && !oscBypassSelect |-> $past(st_q.oscCnt) == '0)
    else $error("stable flag rose before start-up elapsed");

  chk_lock_restart: assert property (
    accWr && apbReq.paddr == OFF_PLL_CFG |=> !pllLockFlag)
    else $error("lock not cleared by pll write");

  chk_lock_rise: assert property (
    $rose(pllLockFlag) |-> $past(st_q.lockCnt) == '0 && pllFeedbackFactor != '0)
    else $error("lock rose before settle count elapsed");

  chk_freq_valid: assert property (
    st_q.freqValid |-> (mainOscEnable || oscBypassSelect) && st_q.meas == MEAS_DONE)
    else $error("frequency valid without finished measurement");

  chk_usb_enable: assert property (
    accWr && apbReq.paddr == OFF_SYS_EN && apbReq.pwdata[7] |=> usbPortClockState)
    else $error("usb port clock not enabled by write");

  chk_prog_disable: assert property (
    accWr && apbReq.paddr == OFF_SYS_DIS
      |=> ((progClockState & $past(apbReq.pwdata[11:8])) == '0))
    else $error("programmable clock still on after disable");

  chk_usb_ratio: assert property (
    accWr && apbReq.paddr == OFF_PLL_CFG && apbReq.pwdata[29:28] != 2'b11
      |=> usbClockShift == $past(apbReq.pwdata[29:28]))
    else $error("usb divider not applied");

  chk_pll_off: assert property (
    pllFeedbackFactor == '0 |-> !pllRun && !pllLockFlag)
    else $error("pll active with zero multiplier");

  cov_osc_start: cover property ($rose(mainOscStableFlag) && mainOscEnable);
  cov_bypass: cover property ($rose(mainOscStableFlag) && oscBypassSelect);
  cov_pll_lock: cover property ($rose(pllLockFlag));
  cov_freq_done: cover property ($rose(st_q.freqValid));
  cov_cpu_idle: cover property ($fell(cpuClockState));

endmodule

/* testbench/ccg_clock_ctrl_tb_top.sv */
// self-checking bench for the clock gating, oscillator and pll control block
`timescale 1ns/100ps
module ccg_clock_ctrl_tb_top;
  import ccg_pkg::*;

  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] exp;
  } ccg_row_t;

  logic         clk;
  logic         rstn;
  ccg_apb_req_t apbReq;
  ccg_apb_rsp_t apbRsp;
  logic         slowClkIn = 1'b0;
  logic         mainClkIn = 1'b0;
  logic         cpuClockState;
  logic         usbPortClockState;
  logic [3:0]   progClockState;
  logic [31:0]  peripheralGate;
  logic         mainOscEnable;
  logic         oscBypassSelect;
  logic         mainOscStableFlag;
  logic         pllLockFlag;
  logic         pllRun;
  logic [7:0]   pllDivide;
  logic [10:0]  pllFeedbackFactor;
  logic [1:0]   pllRange;
  logic [1:0]   usbClockShift;
  int           divCnt = 0;
  int           err_count;
  int           comparisons;
  int           n;
  logic [31:0]  rdData;
  logic         rdErr;

  // write then read back; a write-only target is read through its status register
  ccg_row_t rows [8] = '{
    '{OFF_PER_EN,  32'h0000_0113, OFF_PER_STAT, 32'h0000_0110},
    '{OFF_PER_EN,  32'hf000_0000, OFF_PER_STAT, 32'hf000_0110},
    '{OFF_PER_DIS, 32'h0000_0010, OFF_PER_STAT, 32'hf000_0100},
    '{OFF_PER_DIS, 32'h0000_0003, OFF_PER_STAT, 32'hf000_0100},
    '{OFF_SYS_EN,  32'h0000_0f80, OFF_SYS_STAT, 32'h0000_0f81},
    '{OFF_SYS_DIS, 32'h0000_0280, OFF_SYS_STAT, 32'h0000_0d01},
    '{OFF_SYS_DIS, 32'h0000_0001, OFF_SYS_STAT, 32'h0000_0d00},
    '{OFF_PLL_CFG, 32'h1006_4a05, OFF_PLL_CFG,  32'h1006_4a05}};
  // read-only view after reset; write fields unused
  ccg_row_t rstRows [6] = '{
    '{8'h00, 32'h0, OFF_SYS_STAT,    32'h0000_0001},
    '{8'h00, 32'h0, OFF_PER_STAT,    32'h0000_0000},
    '{8'h00, 32'h0, OFF_OSC_CFG,     32'h0000_0000},
    '{8'h00, 32'h0, OFF_FREQ,        32'h0000_0000},
    '{8'h00, 32'h0, OFF_PLL_CFG,     32'h0000_3f00},
    '{8'h00, 32'h0, OFF_SHARED_STAT, 32'h0000_0008}};

  ccg_clock_ctrl u_dut (
    .clk               (clk),
    .rstn              (rstn),
    .apbReq            (apbReq),
    .apbRsp            (apbRsp),
    .slowClkIn         (slowClkIn),
    .mainClkIn         (mainClkIn),
    .cpuClockState     (cpuClockState),
    .usbPortClockState (usbPortClockState),
    .progClockState    (progClockState),
    .peripheralGate    (peripheralGate),
    .mainOscEnable     (mainOscEnable),
    .oscBypassSelect   (oscBypassSelect),
    .mainOscStableFlag (mainOscStableFlag),
    .pllLockFlag       (pllLockFlag),
    .pllRun            (pllRun),
    .pllDivide         (pllDivide),
    .pllFeedbackFactor (pllFeedbackFactor),
    .pllRange          (pllRange),
    .usbClockShift     (usbClockShift)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // slow clock 20 cycles, main clock 4 cycles: 16 slow periods hold 80 main edges
  always @(posedge clk) begin
    divCnt    <= divCnt + 1;
    slowClkIn <= (divCnt % 20) < 10;
    mainClkIn <= divCnt[1];
  end

  task final_report;
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task timedOut(input string name);
    err_count++;
    $display("BAD %s exp done got timeout", name);
    final_report();
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // one apb transfer; caller stands just after a rising edge
  task apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    apbReq.psel    <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite  <= wr;
    apbReq.paddr   <= a;
    apbReq.pwdata  <= d;
    @(posedge clk);
    apbReq.penable <= 1'b1;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (apbRsp.pready !== 1'b1 && w < 20);
    if (apbRsp.pready !== 1'b1) timedOut("pready");
    rdData = apbRsp.prdata;
    rdErr  = apbRsp.pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
    apbReq.pwrite  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic waitHigh(input string name, ref logic f, input int lim);
    int k;
    k = 0;
    while (f !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (f !== 1'b1) timedOut(name);
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    timedOut("run");
  end

  initial begin
    apbReq = '0;
    rstn = 1'b0;
    err_count = 0;
    comparisons = 0;
    cyc(20);
    rstn <= 1'b1;
    cyc(1);
    foreach (rows[i]) begin
      apbXfer(1'b1, rows[i].wa, rows[i].wd);
      apbXfer(1'b0, rows[i].ra, 32'h0);
      chk("table", rows[i].exp, rdData);
    end
    chk("gate", 32'hf000_0100, peripheralGate);
    chk("cpu", 32'h0, {31'h0, cpuClockState});
    chk("sys out", 32'h0000_000d, {27'h0, usbPortClockState, progClockState});
    // refused, write-only and read-only places
    apbXfer(1'b0, 8'h0c, 32'h0);
    chk("slverr", 32'h1, {31'h0, rdErr});
    apbXfer(1'b0, OFF_PER_EN, 32'h0);
    chk("wo read", 32'h0, rdData);
    apbXfer(1'b1, OFF_PER_STAT, 32'hffff_ffff);
    apbXfer(1'b0, OFF_PER_STAT, 32'h0);
    chk("ro write", 32'hf000_0100, rdData);
    // start-up of 2 x 8 slow ticks cannot finish before 300 cycles
    apbXfer(1'b1, OFF_OSC_CFG, 32'h0000_0201);
    cyc(288);
    chk("stable early", 32'h0, {31'h0, mainOscStableFlag});
    waitHigh("stable", mainOscStableFlag, 80);
    chk("osc on", 32'h1, {31'h0, mainOscEnable});
    apbXfer(1'b0, OFF_SHARED_STAT, 32'h0);
    chk("shared", 32'h0000_000d, rdData);
    n = 0;
    do begin
      apbXfer(1'b0, OFF_FREQ, 32'h0);
      n++;
    end while (rdData[16] !== 1'b1 && n < 200);
    if (rdData[16] !== 1'b1) timedOut("freq");
    chk("freq", 32'h0001_0050, rdData);
    apbXfer(1'b1, OFF_OSC_CFG, 32'h0);
    cyc(1);
    chk("stable clr", 32'h0, {31'h0, mainOscStableFlag});
    apbXfer(1'b0, OFF_FREQ, 32'h0);
    chk("freq valid", 32'h0, {31'h0, rdData[16]});
    // long start-up value proves bypass does not wait for it
    apbXfer(1'b1, OFF_OSC_CFG, 32'h0000_ff02);
    cyc(1);
    chk("bypass", 32'h3, {29'h0, mainOscEnable, oscBypassSelect, mainOscStableFlag});
    apbXfer(1'b1, OFF_OSC_CFG, 32'h0);
    // pll relock with settle 4 ticks
    apbXfer(1'b1, OFF_PLL_CFG, 32'h0003_c401);
    chk("lock clr", 32'h0, {31'h0, pllLockFlag});
    cyc(53);
    chk("lock early", 32'h0, {31'h0, pllLockFlag});
    waitHigh("lock", pllLockFlag, 100);
    chk("pll out", {10'h0, 2'h3, 1'b1, 8'h01, 11'h003},
        {10'h0, pllRange, pllRun, pllDivide, pllFeedbackFactor});
    apbXfer(1'b1, OFF_PLL_CFG, 32'h0000_0401);
    chk("pll off", 32'h0, {30'h0, pllRun, pllLockFlag});
    cyc(150);
    chk("no lock", 32'h0, {31'h0, pllLockFlag});
    apbXfer(1'b1, OFF_PLL_CFG, 32'h0003_0400);
    chk("div zero", 32'h0, {31'h0, pllRun});
    for (int u = 0; u < 4; u++) begin
      apbXfer(1'b1, OFF_PLL_CFG, {2'b00, u[1:0], 28'h003_0401});
      chk("usb", (u == 3) ? 32'h2 : u, {30'h0, usbClockShift});
    end
    apbXfer(1'b0, OFF_PLL_CFG, 32'h0);
    chk("pll rd", 32'h3003_0401, rdData);
    // second reset in mid-run
    rstn <= 1'b0;
    cyc(3);
    chk("rst cpu", 32'h1, {31'h0, cpuClockState});
    chk("rst gate", 32'h0, peripheralGate);
    rstn <= 1'b1;
    cyc(1);
    foreach (rstRows[i]) begin
      apbXfer(1'b0, rstRows[i].ra, 32'h0);
      chk("reset", rstRows[i].exp, rdData);
    end
    final_report();
  end
endmodule
